// File: design/tlb_mgmt.sv
// tlb storage with read, search and sync instruction execution
`timescale 1ns/1ps
`include "tlb_mgmt_map.svh"

// Operation
// - a read (opcode 31, extended 946) picks the entry indexed by bits 26:31 of the base value.
// - word select 0 returns page number, valid, space and size and copies the entry id to the search id.
// - word select 1 returns real page number, zeros in bits 24:27 and extended real page number.
// - word select 2 returns zeros, user and storage attributes, a zero and six permission bits.
// - parity bits appear in the result only while the cache read parity enable is set.
// - a word select above 2 is an invalid form whose result and search id are undefined.
// - a search need not see a search id just loaded by a read without an instruction sync.
// - a search id loaded by a read is seen by a following write or register move unaided.
// - read and search run only in privileged state.
// - a search (extended 914) adds the index value to the base value, or to zero if the base field is 0.
// - a search looks for a valid entry matching the address, the search id and the search space.
// - on a hit the entry index lands in bits 26:31 with bits 0:25 cleared.
// - with the record bit set, condition field 0 gets 0, 0, hit, summary overflow.
// - the tlb sync (extended 566) does nothing.
// - the tlb sync is privileged and works with translation on or off.
module tlb_mgmt
    import tlb_mgmt_pkg::*;
#(
    parameter int ENTRIES = 64
)
(
    input wire logic i_clk, // core clock
    input wire logic i_rst_n, // synchronous reset, active low
    input wire logic i_valid, // instruction issued this cycle
    input wire logic [31:0] i_instr, // instruction word
    input wire logic [31:0] i_base_val, // contents of base_gpr
    input wire logic [31:0] i_index_val, // contents of index_gpr
    input wire logic i_user_mode, // core is in user state
    input wire logic i_cache_read_parity_enable, // core_config_reg0 parity read enable
    input wire logic i_summary_overflow, // summary overflow of the exception register
    input wire logic i_search_translation_space, // search space of mmu_control_reg
    input wire logic i_search_translation_id_load, // register move into the search id
    input wire logic [7:0] i_search_translation_id_val, // value for that move
    input wire logic i_wr_en, // tlb write request
    input wire logic [5:0] i_wr_idx, // tlb write entry index
    input wire logic [4:0] i_wr_ws, // tlb write word select
    input wire logic [31:0] i_wr_data, // tlb write source word
    output logic o_done, // instruction finished, one-cycle pulse
    output logic o_rt_we, // write target_gpr
    output logic [4:0] o_rt_addr, // target_gpr number
    output logic [31:0] o_rt_data, // target_gpr value
    output logic o_cr0_we, // write condition_field0
    output logic [3:0] o_cr0, // condition_field0 value, bit 0 leftmost
    output logic o_hit, // search found an entry
    output logic o_priv_trap, // privileged-instruction program interrupt
    output logic o_invalid_form, // word select above 2 seen
    output logic [7:0] o_search_translation_id // search id of mmu_control_reg
);

    if (ENTRIES != 64)
    begin : g_bad_entries
        $error("tlb_mgmt serves exactly 64 entries");
    end

    typedef struct packed {
        tlb_entry_t [63:0] tlb;
        logic [7:0] search_translation_id;
        logic done;
        logic rt_we;
        logic [4:0] rt_addr;
        logic [31:0] rt_data;
        logic cr0_we;
        logic [3:0] cr0;
        logic hit;
        logic priv_trap;
        logic invalid_form;
    } state_t;

    state_t state_q;
    state_t state_d;

    // ea page mask for an entry size, 1 kb times four to the size, sizes above 10 masked as 10
    function automatic logic [21:0] page_mask(input logic [3:0] size);
        logic [21:0] m;
        m = 22'h3fffff;
        for (int k = 0; k < 10; k++)
        begin
            if (4'(k) < size)
            begin
                m = m << 2;
            end
        end
        return m;
    endfunction

    // tag parity over page number, flags and id
    function automatic logic [3:0] tag_par(input tlb_entry_t e);
        return {^e.effective_page_number[21:11], ^e.effective_page_number[10:0], ^{e.valid, e.ts, e.size}, ^e.translation_id};
    endfunction

    // instruction decode
    logic [5:0] opcode;
    logic [9:0] xo;
    logic [4:0] ra_field;
    logic [4:0] ws;
    tlb_op_t op;
    always_comb
    begin
        opcode = i_instr[`TLBM_OP_MSB:`TLBM_OP_LSB];
        xo = i_instr[`TLBM_XO_MSB:`TLBM_XO_LSB];
        ra_field = i_instr[`TLBM_RA_MSB:`TLBM_RA_LSB];
        ws = i_instr[`TLBM_RB_MSB:`TLBM_RB_LSB];
        op = OP_NONE;
        if (i_valid && opcode == `TLBM_PRIMARY_OP)
        begin
            unique case (xo)
                `TLBM_XO_READ: op = OP_READ;
                `TLBM_XO_SEARCH: op = OP_SEARCH;
                `TLBM_XO_SYNC: op = OP_SYNC;
                default: op = OP_NONE;
            endcase
        end
    end

    // associative search, lowest matching index wins
    logic [31:0] ea;
    logic [5:0] hit_idx;
    logic hit_any;
    always_comb
    begin
        ea = ((ra_field == `TLBM_RA_ZERO) ? 32'h0000_0000 : i_base_val) + i_index_val;
        hit_idx = 6'h00;
        hit_any = 1'b0;
        for (int i = 63; i >= 0; i--)
        begin
            if (state_q.tlb[i].valid && state_q.tlb[i].ts == i_search_translation_space
                && (state_q.tlb[i].translation_id == `TLBM_SHARED_TID
                    || state_q.tlb[i].translation_id == state_q.search_translation_id)
                && ((state_q.tlb[i].effective_page_number ^ ea[31:10]) & page_mask(state_q.tlb[i].size))
                    == 22'h000000)
            begin
                hit_idx = 6'(i);
                hit_any = 1'b1;
            end
        end
    end

    // next state
    tlb_entry_t rd_e;
    tlb_entry_t wr_e;
    logic par_en;
    always_comb
    begin
        state_d = state_q;
        state_d.done = 1'b0;
        state_d.rt_we = 1'b0;
        state_d.cr0_we = 1'b0;
        state_d.priv_trap = 1'b0;
        state_d.invalid_form = 1'b0;
        rd_e = state_q.tlb[i_base_val[5:0]];
        par_en = i_cache_read_parity_enable;
        if (i_search_translation_id_load)
        begin
            state_d.search_translation_id = i_search_translation_id_val;
        end
        if (op != OP_NONE)
        begin
            state_d.done = 1'b1;
            // target number held until the next instruction
            state_d.rt_addr = i_instr[`TLBM_RT_MSB:`TLBM_RT_LSB];
            if (i_user_mode)
            begin
                state_d.priv_trap = 1'b1;
            end
            else
            begin
                unique case (op)
                    OP_READ:
                    begin
                        state_d.rt_we = 1'b1;
                        if (ws == `TLBM_WS_TAG)
                        begin
                            state_d.rt_data = {rd_e.effective_page_number, rd_e.valid, rd_e.ts, rd_e.size,
                                               par_en ? rd_e.tag_parity : 4'h0};
                            state_d.search_translation_id = rd_e.translation_id;
                        end
                        else if (ws == `TLBM_WS_DATA)
                        begin
                            state_d.rt_data = {rd_e.real_page_number, par_en ? rd_e.data_parity : 2'h0,
                                               4'h0, rd_e.extended_real_page_number};
                        end
                        else if (ws == `TLBM_WS_ATTR)
                        begin
                            state_d.rt_data = {par_en ? rd_e.attribute_parity : 2'h0, 14'h0000,
                                               rd_e.attr, 1'b0, rd_e.perm};
                        end
                        else
                        begin
                            // invalid form, zero result, id kept
                            state_d.rt_data = 32'h0000_0000;
                            state_d.invalid_form = 1'b1;
                        end
                    end
                    OP_SEARCH:
                    begin
                        state_d.rt_we = 1'b1;
                        state_d.rt_data = {26'h0000000, hit_idx};
                        state_d.hit = hit_any;
                        state_d.cr0_we = i_instr[`TLBM_RC_BIT];
                        state_d.cr0 = i_instr[`TLBM_RC_BIT]
                            ? {2'h0, hit_any, i_summary_overflow} : state_q.cr0;
                    end
                    OP_SYNC: ;
                    default: ;
                endcase
            end
        end
        // tlb write; tag word takes the current search id so a read before it is seen
        wr_e = state_q.tlb[i_wr_idx];
        if (i_wr_en)
        begin
            if (i_wr_ws == `TLBM_WS_TAG)
            begin
                wr_e.effective_page_number = i_wr_data[31:10];
                wr_e.valid = i_wr_data[9];
                wr_e.ts = i_wr_data[8];
                wr_e.size = i_wr_data[7:4];
                wr_e.translation_id = state_q.search_translation_id;
                wr_e.tag_parity = tag_par(wr_e);
            end
            else if (i_wr_ws == `TLBM_WS_DATA)
            begin
                wr_e.real_page_number = i_wr_data[31:10];
                wr_e.extended_real_page_number = i_wr_data[3:0];
                wr_e.data_parity = {^wr_e.real_page_number[21:11], ^{wr_e.real_page_number[10:0], wr_e.extended_real_page_number}};
            end
            else if (i_wr_ws == `TLBM_WS_ATTR)
            begin
                wr_e.attr = i_wr_data[15:7];
                wr_e.perm = i_wr_data[5:0];
                wr_e.attribute_parity = {^wr_e.attr, ^wr_e.perm};
            end
            state_d.tlb[i_wr_idx] = wr_e;
        end
    end

    // state register
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            state_q <= '0;
            state_q.search_translation_id <= `TLBM_SEARCH_TRANSLATION_ID_RESET;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // outputs straight from the state flops
    assign o_done = state_q.done;
    assign o_rt_we = state_q.rt_we;
    assign o_rt_addr = state_q.rt_addr;
    assign o_rt_data = state_q.rt_data;
    assign o_cr0_we = state_q.cr0_we;
    assign o_cr0 = state_q.cr0;
    assign o_hit = state_q.hit;
    assign o_priv_trap = state_q.priv_trap;
    assign o_invalid_form = state_q.invalid_form;
    // search id visible the next cycle
    assign o_search_translation_id = state_q.search_translation_id;

    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_user_traps: assert property (
        op != OP_NONE && i_user_mode |=> o_priv_trap && !o_rt_we && !o_cr0_we)
        else $error("user-state tlb op did not trap cleanly");
    a_read_index: assert property (
        op == OP_READ && !i_user_mode && ws == `TLBM_WS_DATA && !i_wr_en
        |=> o_rt_data[3:0] == $past(state_q.tlb[i_base_val[5:0]].extended_real_page_number))
        else $error("read returned wrong entry");
    a_read_search_translation_id: assert property (
        op == OP_READ && !i_user_mode && ws == `TLBM_WS_TAG && !i_search_translation_id_load
        |=> o_search_translation_id == $past(state_q.tlb[i_base_val[5:0]].translation_id))
        else $error("search id not copied from entry");
    a_word1_zeros: assert property (
        op == OP_READ && !i_user_mode && ws == `TLBM_WS_DATA |=> o_rt_data[7:4] == 4'h0)
        else $error("word 1 zero field not clear");
    a_word2_zeros: assert property (
        op == OP_READ && !i_user_mode && ws == `TLBM_WS_ATTR
        |=> o_rt_data[29:16] == 14'h0000 && !o_rt_data[6])
        else $error("word 2 zero fields not clear");
    a_parity_off: assert property (
        op == OP_READ && !i_user_mode && !i_cache_read_parity_enable && ws == `TLBM_WS_TAG
        |=> o_rt_data[3:0] == 4'h0)
        else $error("parity shown while disabled");
    a_bad_ws: assert property (
        op == OP_READ && !i_user_mode && ws > `TLBM_WS_ATTR |=> o_invalid_form)
        else $error("invalid word select not flagged");
    a_hit_index: assert property (
        op == OP_SEARCH && !i_user_mode |=> o_rt_data[31:6] == 26'h0000000
        && (!o_hit || state_q.tlb[o_rt_data[5:0]].valid || $past(i_wr_en)))
        else $error("search index malformed");
    a_cr0_form: assert property (
        op == OP_SEARCH && !i_user_mode && i_instr[0]
        |=> o_cr0_we && o_cr0[3:2] == 2'h0 && o_cr0[1] == o_hit
        && o_cr0[0] == $past(i_summary_overflow))
        else $error("condition field wrong after search");
    a_sync_nop: assert property (
        op == OP_SYNC && !i_search_translation_id_load
        |=> o_done && !o_rt_we && !o_cr0_we && $stable(o_search_translation_id))
        else $error("tlb sync had a side effect");

    c_read_hit: cover property (op == OP_READ && !i_user_mode ##1 o_rt_we);
    c_search_hit: cover property (op == OP_SEARCH ##1 o_hit && o_cr0_we);
    c_user_trap: cover property (op == OP_SYNC && i_user_mode ##1 o_priv_trap);

endmodule // tlb_mgmt

// File: design/tlb_mgmt_map.svh
// constants for the tlb management instruction unit
`ifndef TLB_MGMT_MAP_SVH
`define TLB_MGMT_MAP_SVH
// instruction encodings
`define TLBM_PRIMARY_OP 6'h1f
`define TLBM_XO_READ 10'h3b2
`define TLBM_XO_SEARCH 10'h392
`define TLBM_XO_SYNC 10'h236
// instruction field positions, little-endian index into the 32-bit word
`define TLBM_OP_MSB 31
`define TLBM_OP_LSB 26
`define TLBM_RT_MSB 25
`define TLBM_RT_LSB 21
`define TLBM_RA_MSB 20
`define TLBM_RA_LSB 16
`define TLBM_RB_MSB 15
`define TLBM_RB_LSB 11
`define TLBM_XO_MSB 10
`define TLBM_XO_LSB 1
`define TLBM_RC_BIT 0
// word select values and the zero base register field
`define TLBM_WS_TAG 5'h00
`define TLBM_WS_DATA 5'h01
`define TLBM_WS_ATTR 5'h02
`define TLBM_RA_ZERO 5'h00
// reset value and shared translation id
`define TLBM_SEARCH_TRANSLATION_ID_RESET 8'h00
`define TLBM_SHARED_TID 8'h00
`endif

// File: design/tlb_mgmt_pkg.sv
// types for the tlb management instruction unit
package tlb_mgmt_pkg;
    // one tlb entry, three words plus parity and id
    typedef struct packed {
        logic [21:0] effective_page_number;
        logic valid;
        logic ts;
        logic [3:0] size;
        logic [3:0] tag_parity;
        logic [7:0] translation_id;
        logic [21:0] real_page_number;
        logic [1:0] data_parity;
        logic [3:0] extended_real_page_number;
        logic [1:0] attribute_parity;
        logic [8:0] attr;
        logic [5:0] perm;
    } tlb_entry_t;
    typedef enum logic [1:0] {
        OP_NONE,
        OP_READ,
        OP_SEARCH,
        OP_SYNC
    } tlb_op_t;
endpackage

// File: dv/core_model.sv
// core pipeline stand-in: issues tlb instructions, keeps target registers
`timescale 1ns/1ps
module core_model
(
    input wire logic i_clk, // core clock
    input wire logic i_rt_we, // target write pulse
    input wire logic [4:0] i_rt_addr, // target number
    input wire logic [31:0] i_rt_data, // target value
    output logic o_valid, // instruction issued
    output logic [31:0] o_instr, // instruction word
    output logic [31:0] o_base_val, // base register value
    output logic [31:0] o_index_val, // index register value
    output logic o_user_mode // user state
);
    logic [31:0] gpr [32];
    // register file takes the unit's target writes
    always_ff @(posedge i_clk)
    begin
        if (i_rt_we)
            gpr[i_rt_addr] <= i_rt_data;
    end
    // idle until the first instruction
    initial
    begin
        {o_valid, o_user_mode, o_instr, o_base_val, o_index_val} = '0;
    end
    // one instruction held for a single edge; operands then show garbage
    task automatic issue(input logic [31:0] w, input logic [31:0] b,
        input logic [31:0] x, input logic u);
        @(posedge i_clk);
        #1;
        {o_valid, o_instr, o_base_val, o_index_val, o_user_mode} = {1'b1, w, b, x, u};
        @(posedge i_clk);
        #1;
        {o_valid, o_instr, o_base_val, o_index_val, o_user_mode} = {1'b0, ~w, ~b, ~x, ~u};
    endtask
endmodule // core_model

// File: dv/tb_top.sv
// self-checking bench for the tlb management unit
`timescale 1ns/1ps
`include "tlb_mgmt_map.svh"
module tb_top;
    import tlb_mgmt_pkg::*;
    logic i_clk = 1'b0, i_rst_n = 1'b0, i_valid, i_user_mode;
    logic [31:0] i_instr, i_base_val, i_index_val, i_wr_data = '0;
    logic i_cache_read_parity_enable = 1'b0, i_summary_overflow = 1'b0;
    logic i_search_translation_space = 1'b0, i_search_translation_id_load = 1'b0, i_wr_en = 1'b0;
    logic [7:0] i_search_translation_id_val = '0, o_search_translation_id, search_translation_id = '0;
    logic [5:0] i_wr_idx = '0;
    logic [4:0] i_wr_ws = '0, o_rt_addr, rt, ra;
    logic o_done, o_rt_we, o_cr0_we, o_hit, o_priv_trap, o_invalid_form;
    logic [31:0] o_rt_data;
    logic [3:0] o_cr0, cr = '0;
    logic [9:0] xos [3] = '{`TLBM_XO_READ, `TLBM_XO_SEARCH, `TLBM_XO_SYNC};
    int n_mismatch = 0, checks_done = 0, used [$];
    tlb_entry_t mdl [64] = '{default: '0};
    always #4 i_clk = ~i_clk;
    tlb_mgmt uut (.i_clk, .i_rst_n, .i_valid, .i_instr, .i_base_val, .i_index_val,
        .i_user_mode, .i_cache_read_parity_enable, .i_summary_overflow,
        .i_search_translation_space, .i_search_translation_id_load, .i_search_translation_id_val, .i_wr_en, .i_wr_idx,
        .i_wr_ws, .i_wr_data, .o_done, .o_rt_we, .o_rt_addr, .o_rt_data, .o_cr0_we,
        .o_cr0, .o_hit, .o_priv_trap, .o_invalid_form, .o_search_translation_id);
    core_model cm (.i_clk, .i_rt_we(o_rt_we), .i_rt_addr(o_rt_addr), .i_rt_data(o_rt_data),
        .o_valid(i_valid), .o_instr(i_instr), .o_base_val(i_base_val),
        .o_index_val(i_index_val), .o_user_mode(i_user_mode));
    task automatic end_sim();
        if (n_mismatch == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %0t got %h want %h", $time, s, e);
        end
    endtask
    // done, rt write, cr write, trap, invalid form
    task automatic pulses(input logic [4:0] e);
        chk(32'({o_done, o_rt_we, o_cr0_we, o_priv_trap, o_invalid_form}), 32'(e));
    endtask
    // side port: search id move or tlb write, one cycle each
    task automatic side(input logic ld, input logic [7:0] v, input logic we,
        input logic [5:0] ix, input logic [4:0] ws, input logic [31:0] d);
        @(posedge i_clk);
        #1;
        {i_search_translation_id_load, i_search_translation_id_val, i_wr_en, i_wr_idx, i_wr_ws, i_wr_data} = {ld, v, we, ix, ws, d};
        if (ld)
            search_translation_id = v;
        if (we && ws == 5'h0)
            {mdl[ix].effective_page_number, mdl[ix].valid, mdl[ix].ts, mdl[ix].size, mdl[ix].translation_id} = {d[31:4], search_translation_id};
        if (we && ws == 5'h1)
            {mdl[ix].real_page_number, mdl[ix].extended_real_page_number} = {d[31:10], d[3:0]};
        if (we && ws == 5'h2)
            {mdl[ix].attr, mdl[ix].perm} = {d[15:7], d[5:0]};
        @(posedge i_clk);
        #1;
        {i_search_translation_id_load, i_wr_en, i_search_translation_id_val, i_wr_data} = {2'b00, ~v, ~d};
    endtask
    function automatic logic [31:0] rd_word(int i, int ws, logic pe);
        tlb_entry_t t;
        t = mdl[i];
        if (ws == 0)
            return {t.effective_page_number, t.valid, t.ts, t.size, {^t.effective_page_number[21:11], ^t.effective_page_number[10:0],
                ^{t.valid, t.ts, t.size}, ^t.translation_id} & {4{pe}}};
        if (ws == 1)
            return {t.real_page_number, {^t.real_page_number[21:11], ^{t.real_page_number[10:0], t.extended_real_page_number}} & {2{pe}}, 4'h0, t.extended_real_page_number};
        if (ws == 2)
            return {{^t.attr, ^t.perm} & {2{pe}}, 14'h0, t.attr, 1'b0, t.perm};
        return 32'h0;
    endfunction
    function automatic int srch(logic [31:0] ea, logic sts);
        for (int i = 0; i < 64; i++)
            if (mdl[i].valid && mdl[i].ts == sts && (mdl[i].translation_id == 8'h0 || mdl[i].translation_id == search_translation_id)
                && ((ea[31:10] ^ mdl[i].effective_page_number) >> (2 * mdl[i].size)) == 22'h0)
                return i;
        return -1;
    endfunction
    // hang guard
    initial
    begin
        #400000;
        n_mismatch++;
        end_sim();
    end
    initial
    begin
        int idx, h, ws, k;
        logic [31:0] b, d, ea, e;
        logic so, rc, pe;
        void'($urandom(46));
        repeat (5) @(posedge i_clk);
        #1;
        i_rst_n = 1'b1;
        pulses(5'h00);
        chk(32'(o_search_translation_id), 32'h0);
        // fill entries (both ends of the index range) and read every word select
        for (k = 0; k < 8; k++)
        begin
            idx = k == 0 ? 0 : k == 1 ? 63 : $urandom_range(62, 1);
            used.push_back(idx);
            side(1'b1, 8'($urandom_range(3)), 1'b0, 6'h0, 5'h0, 32'h0);
            d = $urandom;
            d[7:4] = 4'($urandom_range(9));
            d[9] = k != 7;
            side(1'b0, 8'h0, 1'b1, 6'(idx), 5'h0, d);
            side(1'b0, 8'h0, 1'b1, 6'(idx), 5'h1, $urandom);
            side(1'b0, 8'h0, 1'b1, 6'(idx), 5'h2, $urandom);
            for (ws = 0; ws < 4; ws++)
            begin
                pe = 1'($urandom);
                rt = 5'($urandom);
                b = $urandom;
                b[5:0] = 6'(idx);
                i_cache_read_parity_enable = pe;
                cm.issue({`TLBM_PRIMARY_OP, rt, 5'h3, 5'(ws), `TLBM_XO_READ, 1'b0}, b, 0, 0);
                if (ws == 0)
                    search_translation_id = mdl[idx].translation_id;
                pulses(5'h18 | 5'(ws == 3)); // invalid form flag
                chk(o_rt_data, rd_word(idx, ws, pe)); // word layouts
                chk(32'(o_rt_addr), 32'(rt)); // target number
                chk(32'(o_search_translation_id), 32'(search_translation_id)); // search id copy
            end
        end
        // user state: every instruction traps and changes nothing
        side(1'b1, 8'h5a, 1'b0, 6'h0, 5'h0, 32'h0);
        for (k = 0; k < 3; k++)
        begin
            cm.issue({`TLBM_PRIMARY_OP, 5'h1, 5'h0, 5'h0, xos[k], 1'b1}, 0, 0, 1);
            pulses(5'h12); // trap only
            chk(32'({o_search_translation_id, o_cr0}), 32'({8'h5a, cr})); // unchanged
        end
        // searches, each after a sync, with zero and nonzero base fields
        for (k = 0; k < 24; k++)
        begin
            idx = used[$urandom_range(used.size() - 1)];
            ea = k % 4 == 3 ? $urandom : {mdl[idx].effective_page_number, 10'($urandom)};
            side(1'b1, mdl[idx].translation_id, 1'b0, 6'h0, 5'h0, 32'h0);
            {so, rc, rt, b} = {2'($urandom), 5'($urandom), $urandom};
            ra = k % 2 ? 5'($urandom_range(31, 1)) : `TLBM_RA_ZERO;
            i_summary_overflow = so;
            i_search_translation_space = mdl[idx].ts ^ (k % 5 == 4);
            h = srch(ea, i_search_translation_space);
            e = h < 0 ? 32'h0 : 32'(h);
            if (rc)
                cr = {2'b00, 1'(h >= 0), so};
            // sync between id load and search
            cm.issue({`TLBM_PRIMARY_OP, 15'h0, `TLBM_XO_SYNC, 1'b0}, 0, 0, 0);
            pulses(5'h10); // no-op sync
            cm.issue({`TLBM_PRIMARY_OP, rt, ra, 5'h4, `TLBM_XO_SEARCH, rc}, b,
                ra == 5'h0 ? ea : ea - b, 0);
            pulses(5'h18 | (5'(rc) << 2)); // record bit
            chk(o_rt_data, e); // address and index
            chk(32'(o_hit), 32'(h >= 0)); // hit flag
            chk(32'(o_cr0), 32'(cr)); // condition field
        end
        @(posedge i_clk);
        #1;
        chk(cm.gpr[rt], e); // target lands in file
        end_sim();
    end
endmodule // tb_top
